// ---- pixel_packer.sv ----
//
// Contract
// - RGB is full range: black all zeros, white all ones.
// - Composed RGB formats go out on FIFO and DMA channel 1.
// - 32-bit RGB: B low byte, G, R, alpha top byte.
// - Alpha byte is key bit replicated eight times or FIFO 2 byte.
// - 24-bit RGB packs four samples into three dwords cyclically.
// - 24-bit RGB first byte position from DMA base bits 1..0.
// - 16-bit RGB: earlier pixel low half, later pixel high half.
// - 16-bit RGB starting half from DMA base bit 1.
// - 16/15-bit RGB by truncation or error diffusion dithering.
// - RGB-16 packs red 5, green 6, blue 5 bits.
// - Two 15-bit variants: key above red, or key between green and blue.
// - Luma straight binary, black 16, white 235.
// - Chroma offset binary, zero at 128, span plus or minus 112.
// - YUV 4:2:2 packs U0 Y0 V0 Y1, phase from DMA base.
// - YUV 4:1:1 packs eight samples into three dwords.
// - Planar YUV uses channels 1 to 3, phase per plane base.
// - Planar chroma: 4:4:4, 4:2:2, 4:2:0 upper left, 4x4 selected; code matches column mod 4 and line parity only.
// - Endian swap: four bytes for 32 bpp, two bytes for 16 bpp.
module pixel_packer
	import packer_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_enable,
	// configuration
	input wire pix_format_t i_format,
	input wire alpha_src_t i_alpha_src,
	input wire swap_mode_t i_swap,
	input wire chroma_sub_t i_chroma_sub,
	input wire logic [3:0] i_yuv9_pick,
	input wire logic i_dither,
	input wire logic [1:0] i_base_lsb_1,
	input wire logic [1:0] i_base_lsb_2,
	input wire logic [1:0] i_base_lsb_3,
	// pixel stream
	input wire logic i_valid,
	output logic o_ready,
	input wire sample_t i_sample,
	input wire logic i_line_odd,
	// dword stream
	output logic o_valid,
	input wire logic i_ready,
	output dword_t o_dword
);

	// ==========================================================
	// stream state
	logic [23:0] acc;
	logic [2:0] acc_n;
	logic [2:0] sample_idx;
	logic first;
	logic [1:0] plane;
	logic [7:0] hold_u;
	logic [7:0] hold_v;
	logic [7:0] hold_y;
	logic [7:0] hold_y2;
	logic [1:0] first_ph;
	logic [2:0] err_r;
	logic [1:0] err_g;
	logic [2:0] err_b;
	logic [1:0] col;

	logic buf_ready;
	logic pack_valid;
	dword_t pack_dword;
	logic [7:0] next_byte [4];
	logic [2:0] nbytes;
	logic [31:0] raw;

	wire take = i_valid && o_ready && i_enable;
	assign o_ready = buf_ready && (plane == 2'h0);
	// a line start counts from sample zero, whatever came before
	wire [2:0] cur_idx = i_sample.sol ? 3'h0 : sample_idx;
	wire [1:0] cur_col = i_sample.sol ? 2'h0 : col;

	// ==========================================================
	// dither and reduction
	// error diffusion
	wire [8:0] dr = {1'b0, i_sample.r_y} + (i_dither ? {6'h0, err_r} : 9'h0);
	wire [8:0] dg = {1'b0, i_sample.g_u} + (i_dither ? {7'h0, err_g} : 9'h0);
	wire [8:0] db = {1'b0, i_sample.b_v} + (i_dither ? {6'h0, err_b} : 9'h0);
	// saturate to keep full range white
	wire [7:0] sr = dr[8] ? 8'hff : dr[7:0];
	wire [7:0] sg = dg[8] ? 8'hff : dg[7:0];
	wire [7:0] sb = db[8] ? 8'hff : db[7:0];
	wire [15:0] px16 = {sr[7:3], sg[7:2], sb[7:3]};
	wire [15:0] px15h = {i_sample.key, sr[7:3], sg[7:3], sb[7:3]};
	wire [15:0] px15m = {sr[7:3], sg[7:3], i_sample.key, sb[7:3]};
	wire [7:0] alpha = (i_alpha_src == ALPHA_KEY) ? {8{i_sample.key}} :
		(i_alpha_src == ALPHA_FIFO) ? i_sample.alpha : 8'h00;
	wire [7:0] luma = (i_sample.r_y < Y_BLACK) ? Y_BLACK :
		(i_sample.r_y > Y_WHITE) ? Y_WHITE : i_sample.r_y;
	wire [7:0] cu = (i_sample.g_u < C_ZERO - C_SPAN) ? C_ZERO - C_SPAN :
		(i_sample.g_u > C_ZERO + C_SPAN) ? C_ZERO + C_SPAN : i_sample.g_u;
	wire [7:0] cv = (i_sample.b_v < C_ZERO - C_SPAN) ? C_ZERO - C_SPAN :
		(i_sample.b_v > C_ZERO + C_SPAN) ? C_ZERO + C_SPAN : i_sample.b_v;
	wire is_rgb = (i_format <= FMT_RGB15_KM);
	wire is16 = (i_format == FMT_RGB16) || (i_format == FMT_RGB15_KH) ||
		(i_format == FMT_RGB15_KM);

	wire keep_c = (i_chroma_sub == SUB_444) ||
		(i_chroma_sub == SUB_422 && !cur_col[0]) ||
		(i_chroma_sub == SUB_420 && !cur_col[0] && !i_line_odd) ||
		(i_chroma_sub == SUB_YUV9 && cur_col == i_yuv9_pick[1:0] &&
		i_yuv9_pick[2] == i_line_odd);

	// ==========================================================
	// per sample byte emission
	always_comb begin
		nbytes = 3'h0;
		for (int k = 0; k < 4; k++)
			next_byte[k] = 8'h00;
		unique case (i_format)
			FMT_ARGB32: begin
				next_byte[0] = sb;
				next_byte[1] = sg;
				next_byte[2] = sr;
				next_byte[3] = alpha;
				nbytes = 3'h4;
			end
			FMT_RGB24: begin
				next_byte[0] = sb;
				next_byte[1] = sg;
				next_byte[2] = sr;
				nbytes = 3'h3;
			end
			FMT_RGB16: begin
				next_byte[0] = px16[7:0];
				next_byte[1] = px16[15:8];
				nbytes = 3'h2;
			end
			FMT_RGB15_KH: begin
				next_byte[0] = px15h[7:0];
				next_byte[1] = px15h[15:8];
				nbytes = 3'h2;
			end
			FMT_RGB15_KM: begin
				next_byte[0] = px15m[7:0];
				next_byte[1] = px15m[15:8];
				nbytes = 3'h2;
			end
			FMT_YUV422: begin
				if (!cur_idx[0]) begin
					next_byte[0] = cu;
					next_byte[1] = luma;
					next_byte[2] = cv;
					nbytes = 3'h3;
				end else begin
					next_byte[0] = luma;
					nbytes = 3'h1;
				end
			end
			FMT_YUV411: begin
				unique case (cur_idx)
					3'h0: begin
						next_byte[0] = cu;
						next_byte[1] = luma;
						next_byte[2] = cv;
						nbytes = 3'h3;
					end
					3'h1, 3'h7: begin
						next_byte[0] = luma;
						nbytes = 3'h1;
					end
					// second dword waits for the chroma of sample four
					3'h2, 3'h3: nbytes = 3'h0;
					3'h4: begin
						next_byte[0] = cu;
						next_byte[1] = hold_y2;
						next_byte[2] = cv;
						next_byte[3] = hold_y;
						nbytes = 3'h4;
					end
					3'h5: begin
						next_byte[0] = hold_y;
						next_byte[1] = luma;
						nbytes = 3'h2;
					end
					3'h6: begin
						next_byte[0] = cv;
						nbytes = 3'h1;
					end
				endcase
			end
			// luma plane, chroma parked for other planes
			FMT_PLANAR: begin
				next_byte[0] = luma;
				nbytes = 3'h1;
			end
			default: begin
				nbytes = 3'h0;
			end
		endcase
	end

	// ==========================================================
	// start phase
	// byte phase from base, half select from bit one, 32-bit always at phase zero
	wire [1:0] phase = is16 ? {i_base_lsb_1[1], 1'b0} :
		(i_format == FMT_ARGB32) ? PHASE_RESET : i_base_lsb_1;

	// phase is kept, the first dword may need several samples
	wire line_start = take && i_sample.sol;
	wire [2:0] start_n = line_start ? {1'b0, phase} : acc_n;
	wire [1:0] cur_ph = line_start ? phase : first_ph;
	wire first_dw = line_start || first;

	// byte lane accumulation; acc holds up to three pending bytes
	logic [55:0] lane;
	logic [2:0] fill;
	always_comb begin
		lane = {32'h0, acc};
		fill = start_n;
		for (int k = 0; k < 4; k++) begin
			if (3'(k) < nbytes) begin
				lane[8*fill +: 8] = next_byte[k];
				fill = 3'(fill + 3'h1);
			end
		end
	end

	wire emit_px = take && (start_n + nbytes >= 3'h4);

	// ==========================================================
	// endian swap
	// four or two byte swap
	always_comb begin
		raw = lane[31:0];
		unique case (i_swap)
			SWAP_4B: raw = {lane[7:0], lane[15:8], lane[23:16], lane[31:24]};
			SWAP_2B: raw = {lane[23:16], lane[31:24], lane[7:0], lane[15:8]};
			default: raw = lane[31:0];
		endcase
	end

	// first dword writes active lanes only
	wire [3:0] be_first = 4'hf << (first_dw ? cur_ph : 2'h0);
	wire [1:0] plane_chan = (plane == 2'h1) ? CHAN_2 : CHAN_3;

	always_comb begin
		pack_valid = emit_px || (plane != 2'h0);
		pack_dword.data = raw;
		pack_dword.byte_en = be_first;
		pack_dword.channel = CHAN_1;
		if (plane != 2'h0) begin
			pack_dword.data = {4{(plane == 2'h1) ? hold_u : hold_v}};
			// chroma planes on channels 2 and 3
			pack_dword.byte_en = 4'h1 << (plane == 2'h1 ?
				i_base_lsb_2 : i_base_lsb_3);
			pack_dword.channel = plane_chan;
		end
	end

	skid_buffer #(.WIDTH(DWORD_W), .DEPTH(2)) u_buffer (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_enable(i_enable),
		.i_valid(pack_valid),
		.o_ready(buf_ready),
		.i_data(pack_dword),
		.o_valid(o_valid),
		.i_ready(i_ready),
		.o_data(o_dword)
	);

	// ==========================================================
	// state update
	wire [2:0] total = 3'(start_n + nbytes);
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			acc <= 24'h0;
			acc_n <= 3'h0;
			sample_idx <= 3'h0;
			first <= 1'b1;
			plane <= 2'h0;
			hold_u <= C_ZERO;
			hold_v <= C_ZERO;
			hold_y <= Y_BLACK;
			hold_y2 <= Y_BLACK;
			first_ph <= PHASE_RESET;
			err_r <= 3'h0;
			err_g <= 2'h0;
			err_b <= 3'h0;
			col <= 2'h0;
		end else if (i_enable) begin
			if (plane != 2'h0 && buf_ready)
				plane <= (plane == 2'h1) ? 2'h2 : 2'h0;
			if (take) begin
				acc <= emit_px ? lane[55:32] : lane[23:0];
				acc_n <= emit_px ? 3'(total - 3'h4) : total;
				first <= emit_px ? 1'b0 : first_dw;
				first_ph <= cur_ph;
				sample_idx <= 3'(cur_idx + 3'h1);
				col <= 2'(cur_col + 2'h1);
				// luma held for the later dwords
				if (cur_idx == 3'h2)
					hold_y2 <= luma;
				if (cur_idx == 3'h3 || cur_idx == 3'h4)
					hold_y <= luma;
				if (i_format != FMT_YUV411)
					hold_v <= cv;
				hold_u <= cu;
				if (i_format == FMT_PLANAR && keep_c)
					plane <= 2'h1;
				if (is_rgb) begin
					err_r <= sr[2:0];
					err_g <= sg[1:0];
					err_b <= sb[2:0];
				end
			end
		end
	end

	// ==========================================================
	// checks
	// alpha off gives zero top byte
	AST_ALPHA_ZERO: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(emit_px && i_format == FMT_ARGB32 && i_alpha_src == ALPHA_NONE
		&& i_swap == SWAP_NONE) |-> pack_dword.data[31:24] == 8'h00)
		else $error("alpha byte not zero");
	AST_CHAN1: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(pack_valid && plane == 2'h0) |-> pack_dword.channel == CHAN_1)
		else $error("wrong channel");
	AST_KEY_ALPHA: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(emit_px && i_format == FMT_ARGB32 && i_alpha_src == ALPHA_KEY
		&& i_swap == SWAP_NONE) |->
		pack_dword.data[31:24] == {8{i_sample.key}})
		else $error("key not replicated");
	AST_LUMA: assert property (@(posedge i_clock) disable iff (!i_resetn)
		take |-> (luma >= Y_BLACK && luma <= Y_WHITE))
		else $error("luma out of range");
	AST_CHROMA: assert property (@(posedge i_clock) disable iff (!i_resetn)
		take |-> (cu >= 8'h10 && cu <= 8'hf0))
		else $error("chroma out of range");
	// chroma planes follow a kept sample
	AST_PLANES: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(take && i_format == FMT_PLANAR && keep_c) |=> plane == 2'h1)
		else $error("chroma plane missing");
	AST_FIRST_BE: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(emit_px && line_start) |->
		pack_dword.byte_en == (4'hf << phase))
		else $error("first byte enables wrong");
	AST_STALL: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(o_valid && !i_ready && i_enable) |=> (o_valid && $stable(o_dword)))
		else $error("word lost under stall");

endmodule

// ---- packer_pkg.sv ----
package packer_pkg;

	// ==========================================================
	// output formats
	typedef enum logic [3:0] {
		FMT_ARGB32 = 4'h0,
		FMT_RGB24 = 4'h1,
		FMT_RGB16 = 4'h2,
		FMT_RGB15_KH = 4'h3,
		FMT_RGB15_KM = 4'h4,
		FMT_YUV422 = 4'h5,
		FMT_YUV411 = 4'h6,
		FMT_PLANAR = 4'h7
	} pix_format_t;

	// ==========================================================
	// planar chroma patterns
	typedef enum logic [1:0] {
		SUB_444 = 2'h0,
		SUB_422 = 2'h1,
		SUB_420 = 2'h2,
		SUB_YUV9 = 2'h3
	} chroma_sub_t;

	// ==========================================================
	// swap modes
	typedef enum logic [1:0] {
		SWAP_NONE = 2'h0,
		SWAP_2B = 2'h1,
		SWAP_4B = 2'h2
	} swap_mode_t;

	// ==========================================================
	// alpha sources
	typedef enum logic [1:0] {
		ALPHA_NONE = 2'h0,
		ALPHA_KEY = 2'h1,
		ALPHA_FIFO = 2'h2
	} alpha_src_t;

	// incoming sample
	typedef struct packed {
		logic [7:0] r_y;
		logic [7:0] g_u;
		logic [7:0] b_v;
		logic [7:0] alpha;
		logic key;
		logic sol;
	} sample_t;

	// outgoing dword with byte enables and target channel
	typedef struct packed {
		logic [31:0] data;
		logic [3:0] byte_en;
		logic [1:0] channel;
	} dword_t;

	localparam int DWORD_W = $bits(dword_t);
	localparam logic [1:0] CHAN_1 = 2'h0;
	localparam logic [1:0] CHAN_2 = 2'h1;
	localparam logic [1:0] CHAN_3 = 2'h2;
	localparam logic [7:0] Y_BLACK = 8'h10;
	localparam logic [7:0] Y_WHITE = 8'heb;
	localparam logic [7:0] C_ZERO = 8'h80;
	localparam logic [7:0] C_SPAN = 8'h70;
	localparam logic [1:0] PHASE_RESET = 2'h0;

endpackage

// ---- skid_buffer.sv ----
module skid_buffer
	import packer_pkg::*;
#(
	parameter int WIDTH = DWORD_W,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_enable,
	// fill side
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	// drain side
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);

	if (DEPTH != 2 || WIDTH < 1) begin : bad_params
		$error("skid_buffer serves two entries only");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;

	wire push = i_valid && o_ready && i_enable;
	wire pop = o_valid && i_ready && i_enable;

	assign o_ready = (count != 2'h2);
	assign o_valid = (count != 2'h0);
	assign o_data = mem[rd_ptr];

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (push)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			count <= 2'(count + {1'b0, push} - {1'b0, pop});
		end
	end

	always_ff @(posedge i_clock) begin
		if (push)
			mem[wr_ptr] <= i_data;
	end

endmodule

// ---- dword_sink.sv ----
// ==========================================================
// far side model: video fifo and dma channel taking dwords
module dword_sink
	import packer_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// stall mode: 0 none, 1 hold, 2 every other cycle
	input wire logic [1:0] i_mode,
	// dword stream
	input wire logic i_valid,
	output logic o_ready,
	input wire dword_t i_dword
);
	timeunit 1ns;
	timeprecision 100ps;

	dword_t rx_q[$];

	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_ready <= 1'b0;
		end else begin
			if (i_valid && o_ready) begin
				rx_q.push_back(i_dword);
			end
			o_ready <= (i_mode == 2'h0) || (i_mode == 2'h2 && !o_ready);
		end
	end
endmodule

// ---- scaler_output_pixel_packer_test.sv ----
module scaler_output_pixel_packer_test
	import packer_pkg::*;
	;
	timeunit 1ns;
	timeprecision 100ps;

	logic i_clock, i_resetn, i_enable, i_dither, i_valid, i_line_odd;
	logic o_ready, o_valid, sink_ready;
	pix_format_t i_format;
	alpha_src_t i_alpha_src;
	swap_mode_t i_swap;
	chroma_sub_t i_chroma_sub;
	logic [3:0] i_yuv9_pick;
	logic [1:0] i_base_lsb_1, i_base_lsb_2, i_base_lsb_3, stall;
	sample_t i_sample;
	dword_t o_dword;
	int miscompares, total_checks;
	logic [7:0] bq[$];

	pixel_packer i_dut (.i_clock(i_clock), .i_resetn(i_resetn),
		.i_enable(i_enable), .i_format(i_format),
		.i_alpha_src(i_alpha_src), .i_swap(i_swap),
		.i_chroma_sub(i_chroma_sub), .i_yuv9_pick(i_yuv9_pick),
		.i_dither(i_dither), .i_base_lsb_1(i_base_lsb_1),
		.i_base_lsb_2(i_base_lsb_2), .i_base_lsb_3(i_base_lsb_3),
		.i_valid(i_valid), .o_ready(o_ready), .i_sample(i_sample),
		.i_line_odd(i_line_odd), .o_valid(o_valid),
		.i_ready(sink_ready), .o_dword(o_dword));

	dword_sink sink (.i_clock(i_clock), .i_resetn(i_resetn),
		.i_mode(stall), .i_valid(o_valid), .o_ready(sink_ready),
		.i_dword(o_dword));

	// ==========================================================
	// helpers
	task check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function sample_t px(input logic [7:0] r, g, b, a, input logic k, s);
		return {r, g, b, a, k, s};
	endfunction

	function logic [31:0] swp(input logic [31:0] e, input swap_mode_t sw);
		if (sw == SWAP_4B) return {e[7:0], e[15:8], e[23:16], e[31:24]};
		if (sw == SWAP_2B) return {e[23:16], e[31:24], e[7:0], e[15:8]};
		return e;
	endfunction

	task cfg(input pix_format_t f, input logic [1:0] ph,
		input swap_mode_t sw, input alpha_src_t a);
		i_format = f;
		i_base_lsb_1 = ph;
		i_swap = sw;
		i_alpha_src = a;
		bq.delete();
	endtask

	// offer one sample and hold it until taken; valid stays high so
	// back to back samples need no idle edge
	task send(input sample_t s);
		logic r;
		i_sample = s;
		i_valid = 1'b1;
		r = 1'b0;
		for (int n = 0; n < 100 && !r; n++) begin
			@(negedge i_clock);
			r = o_ready;
			@(posedge i_clock);
		end
		if (!r) miscompares++;
		#1;
	endtask

	task get_word(output dword_t w);
		for (int n = 0; n < 200 && sink.rx_q.size() == 0; n++) begin
			@(posedge i_clock);
			#1;
		end
		w = '0;
		if (sink.rx_q.size() == 0) miscompares++;
		else w = sink.rx_q.pop_front();
	endtask

	// bytes fill lanes from the start phase upwards, low lane first
	task expect_words(input logic [7:0] b[$], input int ph,
		input swap_mode_t sw);
		dword_t w;
		logic [31:0] e, m;
		logic [3:0] be;
		int k, l;
		i_valid = 1'b0;
		k = 0;
		l = ph;
		while (k < b.size()) begin
			e = '0;
			m = '0;
			be = 4'hf << l;
			for (int j = l; j < 4; j++) begin
				e[8*j+:8] = b[k];
				m[8*j+:8] = 8'hff;
				k++;
			end
			get_word(w);
			check("data", w.data & m, swp(e, sw));
			check("byte_en", w.byte_en, be);
			check("channel", w.channel, CHAN_1);
			l = 0;
		end
	endtask

	// ==========================================================
	// scenarios
	task t_argb;
		cfg(FMT_ARGB32, 2'h0, SWAP_NONE, ALPHA_KEY);
		send(px(8'hff, 8'hff, 8'hff, 8'h00, 1'b1, 1'b1));
		expect_words('{8'hff, 8'hff, 8'hff, 8'hff}, 0, SWAP_NONE);
		send(px(8'h00, 8'h00, 8'h00, 8'h5a, 1'b0, 1'b1));
		expect_words('{8'h00, 8'h00, 8'h00, 8'h00}, 0, SWAP_NONE);
		cfg(FMT_ARGB32, 2'h3, SWAP_NONE, ALPHA_FIFO);
		send(px(8'h12, 8'h34, 8'h56, 8'h5a, 1'b1, 1'b1));
		expect_words('{8'h56, 8'h34, 8'h12, 8'h5a}, 0, SWAP_NONE);
		cfg(FMT_ARGB32, 2'h0, SWAP_4B, ALPHA_NONE);
		send(px(8'h12, 8'h34, 8'h56, 8'h5a, 1'b1, 1'b1));
		expect_words('{8'h56, 8'h34, 8'h12, 8'h00}, 0, SWAP_4B);
		$display("done argb");
	endtask

	task t_rgb24;
		stall = 2'h2;
		for (int ph = 0; ph < 2; ph++) begin
			cfg(FMT_RGB24, 2'(ph), SWAP_NONE, ALPHA_NONE);
			for (int i = 0; i < 4 + ph; i++) begin
				send(px(8'h10 + 8'(i), 8'h20 + 8'(i), 8'h30 + 8'(i),
					8'h00, 1'b0, i == 0));
				bq.push_back(8'h30 + 8'(i));
				bq.push_back(8'h20 + 8'(i));
				bq.push_back(8'h10 + 8'(i));
			end
			expect_words(bq, ph, SWAP_NONE);
		end
		stall = 2'h0;
		$display("done rgb24");
	endtask

	function logic [15:0] p16(input pix_format_t f, input sample_t s);
		if (f == FMT_RGB16)
			return {s.r_y[7:3], s.g_u[7:2], s.b_v[7:3]};
		if (f == FMT_RGB15_KH)
			return {s.key, s.r_y[7:3], s.g_u[7:3], s.b_v[7:3]};
		return {s.r_y[7:3], s.g_u[7:3], s.key, s.b_v[7:3]};
	endfunction

	task t_rgb16;
		sample_t s;
		pix_format_t fs[3] = '{FMT_RGB16, FMT_RGB15_KH, FMT_RGB15_KM};
		for (int f = 0; f < 3; f++) begin
			for (int j = 0; j < 2; j++) begin
				cfg(fs[f], j ? 2'h0 : 2'h2, j ? SWAP_2B : SWAP_NONE,
					ALPHA_NONE);
				i_dither = (f == 2);
				for (int i = 0; i < 3 - j; i++) begin
					s = px(8'hf8 - 8'h18 * 8'(i), 8'h40 + 8'h18 * 8'(i),
						8'h88 + 8'h08 * 8'(i), 8'h00, i[0], i == 0);
					send(s);
					bq.push_back(p16(fs[f], s)[7:0]);
					bq.push_back(p16(fs[f], s)[15:8]);
				end
				expect_words(bq, j ? 0 : 2, i_swap);
			end
		end
		i_dither = 1'b0;
		$display("done rgb16");
	endtask

	task t_yuv;
		cfg(FMT_YUV422, 2'h0, SWAP_NONE, ALPHA_NONE);
		send(px(8'h05, 8'hff, C_ZERO, 8'h00, 1'b0, 1'b1));
		send(px(Y_WHITE, 8'h80, 8'h80, 8'h00, 1'b0, 1'b0));
		send(px(Y_BLACK, C_ZERO - C_SPAN, C_ZERO + C_SPAN, 8'h00, 1'b0, 1'b0));
		send(px(8'hf5, 8'h80, 8'h80, 8'h00, 1'b0, 1'b0));
		expect_words('{8'hf0, 8'h10, 8'h80, 8'heb, 8'h10, 8'h10, 8'hf0,
			8'heb}, 0, SWAP_NONE);
		cfg(FMT_YUV411, 2'h0, SWAP_NONE, ALPHA_NONE);
		for (int i = 0; i < 8; i++)
			send(px(8'h20 + 8'(i), 8'h40 + 8'(i), 8'h60 + 8'(i), 8'h00,
				1'b0, i == 0));
		expect_words('{8'h40, 8'h20, 8'h60, 8'h21, 8'h44, 8'h22, 8'h64,
			8'h23, 8'h24, 8'h25, 8'h66, 8'h27}, 0, SWAP_NONE);
		$display("done yuv");
	endtask

	// planar 4:2:0: chroma words only on the upper line, even columns
	task t_planar;
		dword_t w;
		cfg(FMT_PLANAR, 2'h0, SWAP_NONE, ALPHA_NONE);
		i_chroma_sub = SUB_420;
		i_base_lsb_2 = 2'h1;
		i_base_lsb_3 = 2'h2;
		for (int l = 0; l < 2; l++) begin
			i_line_odd = l[0];
			for (int i = 0; i < 4; i++)
				send(px(8'h20 + 8'(i), 8'h40 + 8'(i), 8'h60 + 8'(i),
					8'h00, 1'b0, i == 0));
			i_valid = 1'b0;
			for (int i = 0; i < 2 - 2 * l; i++) begin
				get_word(w);
				check("u_lane", w.data[15:8], 8'h40 + 8'(2 * i));
				check("u_be", w.byte_en, 4'h2);
				check("u_chan", w.channel, CHAN_2);
				get_word(w);
				check("v_lane", w.data[23:16], 8'h60 + 8'(2 * i));
				check("v_be", w.byte_en, 4'h4);
				check("v_chan", w.channel, CHAN_3);
			end
			get_word(w);
			check("y_word", w.data, 32'h23222120);
			check("y_be", w.byte_en, 4'hf);
			check("y_chan", w.channel, CHAN_1);
		end
		i_line_odd = 1'b0;
		$display("done planar");
	endtask

	// stalled sink: buffer fills until it refuses, then drains in order
	task t_buffer;
		logic r;
		int n;
		cfg(FMT_ARGB32, 2'h0, SWAP_NONE, ALPHA_NONE);
		stall = 2'h1;
		n = 0;
		i_valid = 1'b1;
		for (int c = 0; c < 10; c++) begin
			i_sample = px(8'h10 + 8'(n), 8'h20, 8'h30, 8'h00, 1'b0, 1'b1);
			@(negedge i_clock);
			r = o_ready;
			@(posedge i_clock);
			if (r) n++;
			#1;
		end
		i_valid = 1'b0;
		check("refused", r, 1'b0);
		check("held", n >= 2, 1'b1);
		i_enable = 1'b0;
		repeat (2) @(posedge i_clock);
		#1;
		i_enable = 1'b1;
		stall = 2'h0;
		for (int i = 0; i < n; i++)
			expect_words('{8'h30, 8'h20, 8'h10 + 8'(i), 8'h00}, 0, SWAP_NONE);
		$display("done buffer");
	endtask

	// ==========================================================
	// run control
	task end_of_test;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end

	initial begin
		#200000;
		miscompares++;
		end_of_test;
	end

	initial begin
		i_resetn = 1'b0;
		i_enable = 1'b1;
		i_dither = 1'b0;
		i_valid = 1'b0;
		i_line_odd = 1'b0;
		i_format = FMT_ARGB32;
		i_alpha_src = ALPHA_NONE;
		i_swap = SWAP_NONE;
		i_chroma_sub = SUB_444;
		i_yuv9_pick = 4'h0;
		i_base_lsb_1 = 2'h0;
		i_base_lsb_2 = 2'h0;
		i_base_lsb_3 = 2'h0;
		i_sample = '0;
		stall = 2'h0;
		miscompares = 0;
		total_checks = 0;
		repeat (2) @(posedge i_clock);
		#1;
		i_resetn = 1'b1;
		t_argb;
		t_rgb24;
		t_rgb16;
		t_yuv;
		t_planar;
		t_buffer;
		end_of_test;
	end
endmodule
